// ---- rtl/pllcl_pkg.sv ----
package pllcl_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Field widths and serial frame layout
    localparam int FB_W = 9;
    localparam int OD_W = 2;
    localparam int TS_W = 3;
    localparam int FRAME_W = 14;
    localparam int FRAME_TS_MSB = 13;
    localparam int FRAME_TS_LSB = 11;
    localparam int FRAME_OD_MSB = 10;
    localparam int FRAME_OD_LSB = 9;
    localparam int FRAME_FB_MSB = 8;
    localparam int FRAME_FB_LSB = 0;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] CONFIG_OFFSET = 8'h08;
    localparam logic [7:0] SHIFT_OFFSET = 8'h0c;

    // Control bits and reset values
    localparam int CTRL_LOOP_EN_BIT = 0;
    localparam int CTRL_OUT_EN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;

    // Status bits
    localparam int ST_LOCKED_BIT = 0;
    localparam int ST_TIMEOUT_BIT = 1;
    localparam int ST_IN_RANGE_BIT = 2;
    localparam int ST_PLOAD_BIT = 3;

    ////////////////////////////////////////////////////////////////////////
    // Divider constants
    localparam int REF_PRESCALE = 16;
    localparam logic [3:0] REF_PRESCALE_LAST = 4'hf;
    localparam int VCO_MIN_MHZ = 400;
    localparam int VCO_MAX_MHZ = 800;
    localparam logic [OD_W-1:0] OD_DIV2 = 2'h0;
    localparam logic [OD_W-1:0] OD_DIV4 = 2'h1;
    localparam logic [OD_W-1:0] OD_DIV8 = 2'h2;
    localparam logic [OD_W-1:0] OD_DIV1 = 2'h3;
    localparam logic [FB_W-1:0] FB_RESET = 9'h0c8;
    localparam logic [OD_W-1:0] OD_RESET = 2'h0;
    localparam logic [TS_W-1:0] TS_RESET = 3'h0;
    localparam logic [TS_W-1:0] TS_TEST_CLOCK = 3'h6;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_MHZ = 50;
    localparam int LOCK_TIME_MS = 10;
    localparam int LOCK_CYC = LOCK_TIME_MS * 1000 * CLK_MHZ * 1000 / 1000;
    localparam logic [3:0] LOCK_MATCHES = 4'h4;

endpackage : pllcl_pkg

// ---- rtl/pllcl_top.sv ----
// Overview of operation
// - Reference input is divided by sixteen to form the comparison window.
// - Loop trims oscillator until its ticks per window equal feedback divide; code aims at feedback divide shifted right by FB_SHIFT.
// - Feedback values outside the 400..800 MHz oscillator range never lock.
// - Output divider selects ratio 1, 2, 4 or 8.
// - Output toggles every ratio ticks, giving 50 percent duty.
// - Parallel inputs captured on rising edge of parallel load strobe.
// - Parallel path wins over serial path.
// - Serial shift register is exactly fourteen bits.
// - Each serial clock rising edge shifts in one data bit.
// - Serial load falling edge transfers frame while parallel strobe high.
// - Test output shows node chosen by three-bit test select.
// - Feedback field is unsigned binary, weights 256 down to 1.
// - Lock is reached, or timeout flagged, within 10 ms of new config.
// - Output select: 00 div2, 01 div4, 10 div8, 11 div1.
// - Frame order: test, output, feedback fields, each msb first.
// - Parallel strobe low makes input latches transparent.
// - Parallel strobe low forces test select to zero.
//
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module pllcl_top
    import pllcl_pkg::*;
#(
    parameter int REF_MHZ = 16,
    parameter int FB_SHIFT = 2,
    parameter int ACC_W = 16,
    parameter logic [15:0] FW_INIT = 16'h4000,
    parameter logic [15:0] FW_STEP = 16'h0040,
    parameter int LOCK_CYCLES = LOCK_CYC
)
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Parallel configuration pins
    input wire logic p_load_n,
    input wire logic [FB_W-1:0] fb_div_in,
    input wire logic [OD_W-1:0] out_div_in,
    // Serial configuration pins
    input wire logic s_clock,
    input wire logic s_data,
    input wire logic s_load,
    // Reference and outputs
    input wire logic external_reference_in,
    output logic synth_output,
    output logic test_output
);

    // Oscillator model is built for a 16-bit accumulator only
    if (ACC_W != 16 || FB_SHIFT < 0 || FB_SHIFT > 4 || REF_MHZ < 1 || LOCK_CYCLES < 1)
    begin : g_bad_params
        $error("pllcl_top: unsupported parameter values");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, two flops per pin
    localparam int PIN_W = 5 + FB_W + OD_W;
    // Strobe idles high in reset, so reset alone never loads zero pins
    localparam logic [PIN_W-1:0] PIN_IDLE = {1'b1, {(PIN_W-1){1'b0}}};
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_meta;
    logic [PIN_W-1:0] pin_sync;
    assign pin_raw = {p_load_n, s_clock, s_data, s_load, external_reference_in,
                      fb_div_in, out_div_in};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi++)
        begin : g_sync
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    pin_meta[gi] <= PIN_IDLE[gi];
                    pin_sync[gi] <= PIN_IDLE[gi];
                end
                else
                begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_sync[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate

    wire p_load_n_s = pin_sync[PIN_W-1];
    wire s_clock_s = pin_sync[PIN_W-2];
    wire s_data_s = pin_sync[PIN_W-3];
    wire s_load_s = pin_sync[PIN_W-4];
    wire ref_s = pin_sync[PIN_W-5];
    wire [FB_W-1:0] fb_pin_s = pin_sync[OD_W +: FB_W];
    wire [OD_W-1:0] od_pin_s = pin_sync[OD_W-1:0];

    // Previous levels for edge detection
    logic s_clock_d;
    logic s_load_d;
    logic ref_d;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_clock_d <= 1'b0;
            s_load_d <= 1'b0;
            ref_d <= 1'b0;
        end
        else
        begin
            s_clock_d <= s_clock_s;
            s_load_d <= s_load_s;
            ref_d <= ref_s;
        end
    end
    wire s_clock_rise = s_clock_s & ~s_clock_d;
    wire s_load_fall = ~s_load_s & s_load_d;
    wire ref_rise = ref_s & ~ref_d;

    ////////////////////////////////////////////////////////////////////////
    // Serial shift register and configuration latches
    logic [FRAME_W-1:0] shift_reg;
    logic [FB_W-1:0] cfg_fb;
    logic [OD_W-1:0] cfg_od;
    logic [TS_W-1:0] cfg_ts;

    // Msb of each field arrives first and ends highest
    wire [FRAME_W-1:0] next_shift_reg = {shift_reg[FRAME_W-2:0], s_data_s};
    // Parallel strobe low keeps serial transfers out
    wire serial_apply = s_load_fall & p_load_n_s;
    wire par_apply = ~p_load_n_s;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            shift_reg <= '0;
        else if (s_clock_rise)
            shift_reg <= next_shift_reg;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cfg_fb <= FB_RESET;
            cfg_od <= OD_RESET;
            cfg_ts <= TS_RESET;
        end
        else if (par_apply)
        begin
            // Transparent while low, value frozen at the rising edge
            cfg_fb <= fb_pin_s;
            cfg_od <= od_pin_s;
            cfg_ts <= TS_RESET;
        end
        else if (serial_apply)
        begin
            cfg_fb <= shift_reg[FRAME_FB_MSB:FRAME_FB_LSB];
            cfg_od <= shift_reg[FRAME_OD_MSB:FRAME_OD_LSB];
            cfg_ts <= shift_reg[FRAME_TS_MSB:FRAME_TS_LSB];
        end
    end

    // Any change of divide values restarts acquisition
    logic [FB_W+OD_W-1:0] cfg_prev;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cfg_prev <= {FB_RESET, OD_RESET};
        else
            cfg_prev <= {cfg_fb, cfg_od};
    end
    wire cfg_changed = cfg_prev != {cfg_fb, cfg_od};

    ////////////////////////////////////////////////////////////////////////
    // Control register
    logic [1:0] ctrl;
    wire loop_en = ctrl[CTRL_LOOP_EN_BIT];
    wire out_en = ctrl[CTRL_OUT_EN_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Reference prescaler
    logic [3:0] ref_cnt;
    logic ref_div;
    wire window_end = ref_rise & (ref_cnt == REF_PRESCALE_LAST);
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ref_cnt <= 4'h0;
            ref_div <= 1'b0;
        end
        else if (ref_rise)
        begin
            ref_cnt <= ref_cnt + 4'h1;
            if (ref_cnt[2:0] == 3'h7)
                ref_div <= ~ref_div;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Oscillator model: phase accumulator, carry is one oscillator tick
    logic [ACC_W-1:0] phase;
    logic [15:0] freq_word;
    logic vco_clk;
    wire [ACC_W:0] phase_sum = {1'b0, phase} + {1'b0, freq_word};
    wire vco_tick = phase_sum[ACC_W];
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase <= '0;
            vco_clk <= 1'b0;
        end
        else
        begin
            phase <= phase_sum[ACC_W-1:0];
            if (vco_tick)
                vco_clk <= ~vco_clk;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frequency loop
    // Oscillator range in feedback units; scaled to fit the model's tick rate
    localparam int FB_MIN = VCO_MIN_MHZ * REF_PRESCALE / (2 * REF_MHZ);
    localparam int FB_MAX = VCO_MAX_MHZ * REF_PRESCALE / (2 * REF_MHZ);
    wire [9:0] fb_min_w = 10'(FB_MIN);
    wire [9:0] fb_max_w = 10'(FB_MAX);
    wire in_range = ({1'b0, cfg_fb} >= fb_min_w) && ({1'b0, cfg_fb} <= fb_max_w);
    wire [9:0] target = 10'({1'b0, cfg_fb} >> FB_SHIFT);

    logic [9:0] tick_cnt;
    logic [3:0] match_cnt;
    logic locked;
    wire count_low = tick_cnt < target;
    wire count_high = tick_cnt > target;
    // Counts dither by one tick per window, so lock accepts one either side
    wire [10:0] tick_ext = {1'b0, tick_cnt};
    wire [10:0] target_ext = {1'b0, target};
    wire off_lock = (tick_ext + 11'h001 < target_ext) || (tick_ext > target_ext + 11'h001);
    wire [16:0] fw_up = {1'b0, freq_word} + {1'b0, FW_STEP};
    wire [15:0] next_fw_up = fw_up[16] ? 16'hffff : fw_up[15:0];
    wire [15:0] next_fw_dn = (freq_word > FW_STEP) ? freq_word - FW_STEP : FW_STEP;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            tick_cnt <= 10'h000;
        else if (window_end)
            tick_cnt <= 10'(vco_tick);
        else if (vco_tick && tick_cnt != 10'h3ff)
            tick_cnt <= tick_cnt + 10'h001;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            freq_word <= FW_INIT;
        else if (window_end && loop_en && count_low)
            freq_word <= next_fw_up;
        else if (window_end && loop_en && count_high)
            freq_word <= next_fw_dn;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            match_cnt <= 4'h0;
            locked <= 1'b0;
        end
        else if (cfg_changed || !in_range || !loop_en)
        begin
            match_cnt <= 4'h0;
            locked <= 1'b0;
        end
        else if (window_end)
        begin
            if (off_lock)
            begin
                match_cnt <= 4'h0;
                locked <= 1'b0;
            end
            else if (match_cnt != LOCK_MATCHES)
                match_cnt <= match_cnt + 4'h1;
            else
                locked <= 1'b1;
        end
    end

    // Lock timer: flags a missed lock at the limit
    logic [31:0] lock_timer;
    logic lock_timeout;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lock_timer <= 32'h0;
            lock_timeout <= 1'b0;
        end
        else if (cfg_changed || locked)
        begin
            lock_timer <= 32'h0;
            lock_timeout <= 1'b0;
        end
        else if (lock_timer == 32'(LOCK_CYCLES - 1))
            lock_timeout <= 1'b1;
        else
            lock_timer <= lock_timer + 32'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Output divider
    logic [2:0] od_cnt;
    wire [2:0] od_last = (cfg_od == OD_DIV1) ? 3'h0 :
                         (cfg_od == OD_DIV2) ? 3'h1 :
                         (cfg_od == OD_DIV4) ? 3'h3 : 3'h7;
    wire od_wrap = vco_tick && (od_cnt >= od_last);
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            od_cnt <= 3'h0;
            synth_output <= 1'b0;
        end
        else if (!out_en)
        begin
            od_cnt <= 3'h0;
            synth_output <= 1'b0;
        end
        else if (od_wrap)
        begin
            od_cnt <= 3'h0;
            // Equal tick counts high and low keep the duty at half
            synth_output <= ~synth_output;
        end
        else if (vco_tick)
            od_cnt <= od_cnt + 3'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Test observation; select zero keeps the pin static
    logic test_sel;
    always_comb
    begin
        unique case (cfg_ts)
            3'h0: test_sel = 1'b0;
            3'h1: test_sel = vco_clk;
            3'h2: test_sel = ref_div;
            3'h3: test_sel = tick_cnt[0];
            3'h4: test_sel = locked;
            3'h5: test_sel = shift_reg[FRAME_W-1];
            3'h6: test_sel = s_clock_s;
            3'h7: test_sel = synth_output;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            test_output <= 1'b0;
        else
            test_output <= test_sel;
    end

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states, always OKAY
    logic dp_write;
    logic [7:0] dp_addr;
    wire ap_valid = hsel & htrans[1] & hready;
    wire [7:0] ap_addr = {haddr[7:2], 2'h0};
    wire ap_mapped = (haddr[31:8] == 24'h0);
    // Timeout hides once lock is in, closing the one-cycle overlap
    wire timeout_shown = lock_timeout & ~locked;
    wire [31:0] status_word = {28'h0, p_load_n_s, in_range, timeout_shown, locked};
    wire [31:0] config_word = {16'h0, cfg_ts, 1'b0, cfg_od, 1'b0, cfg_fb};
    wire [31:0] read_mux =
        !ap_mapped ? 32'h0 :
        (ap_addr == CTRL_OFFSET) ? {30'h0, ctrl} :
        (ap_addr == STATUS_OFFSET) ? status_word :
        (ap_addr == CONFIG_OFFSET) ? config_word :
        (ap_addr == SHIFT_OFFSET) ? {18'h0, shift_reg} : 32'h0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
            hrdata <= 32'h0;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end
        else
        begin
            dp_write <= ap_valid & hwrite & ap_mapped;
            dp_addr <= ap_addr;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (ap_valid && !hwrite)
                hrdata <= read_mux;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl <= CTRL_RESET;
        else if (dp_write && dp_addr == CTRL_OFFSET)
            ctrl <= hwdata[1:0];
    end

endmodule : pllcl_top

`default_nettype wire

// ---- test/pllcl_top_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none

module pllcl_top_asserts
    import pllcl_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Pins
    input wire logic p_load_n,
    input wire logic [FB_W-1:0] fb_div_in,
    input wire logic [OD_W-1:0] out_div_in,
    input wire logic test_output
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    ////////////////////////////////////////////////////////////////////////
    wire rd = hsel && htrans[1] && hready && !hwrite;
    wire rd_cfg = rd && haddr == {24'h0, CONFIG_OFFSET};

    ////////////////////////////////////////////////////////////////////////
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    chk_ready_up: assert property ($past(hresetn) |-> hreadyout)
        else $error("ready low outside reset");
    chk_upper_zero: assert property (rd |=> hrdata[31:16] == 16'h0)
        else $error("upper read bits set");
    chk_unmapped_zero: assert property (rd && haddr[31:8] != 24'h0 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_cfg_gaps: assert property (rd_cfg |=> hrdata[12] == 1'b0 && hrdata[9] == 1'b0)
        else $error("config gap bits set");
    // Six cycles covers the two-stage sync plus the config update
    chk_pins_follow: assert property (
        (!p_load_n && $stable({fb_div_in, out_div_in}))[*6] ##0 rd_cfg
        |=> hrdata[11:0] == {$past(out_div_in), 1'b0, $past(fb_div_in)})
        else $error("config not following pins");
    chk_test_forced: assert property (!p_load_n[*6] ##0 rd_cfg |=> hrdata[15:13] == 3'h0)
        else $error("test select not forced");
    chk_test_static: assert property (!p_load_n[*6] |-> !test_output)
        else $error("test output active");
endmodule : pllcl_top_asserts

`default_nettype wire

// ---- test/pllcl_host.sv ----
`timescale 1ns/1ns
`default_nettype none

module pllcl_host
    import pllcl_pkg::*;
(
    // Clock
    input wire logic hclk,
    // Parallel pins
    output logic p_load_n,
    output logic [FB_W-1:0] fb_div_in,
    output logic [OD_W-1:0] out_div_in,
    // Serial pins
    output logic s_clock,
    output logic s_data,
    output logic s_load
);
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        p_load_n = 1'b0;
        fb_div_in = FB_RESET;
        out_div_in = OD_RESET;
        s_clock = 1'b0;
        s_data = 1'b0;
        s_load = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    task par(input logic [FB_W-1:0] f, input logic [OD_W-1:0] o, input logic lvl);
        @(posedge hclk);
        p_load_n <= 1'b0;
        fb_div_in <= f;
        out_div_in <= o;
        repeat (6) @(posedge hclk);
        p_load_n <= lvl;
        if (lvl)
        begin
            // Pins go stale once hold is over, so capture must have happened
            repeat (3) @(posedge hclk);
            fb_div_in <= ~f;
            out_div_in <= ~o;
        end
    endtask : par

    // Serial clock idles low between frames; data moves on its falling edge
    task ser(input logic [FRAME_W-1:0] v, input logic ld);
        @(posedge hclk);
        s_data <= v[FRAME_W-1];
        for (int i = FRAME_W - 1; i >= 0; i--)
        begin
            repeat (4) @(posedge hclk);
            s_clock <= 1'b1;
            repeat (4) @(posedge hclk);
            s_clock <= 1'b0;
            s_data <= (i > 0) ? v[i - 1] : ~v[0];
        end
        if (ld)
        begin
            repeat (4) @(posedge hclk);
            s_load <= 1'b1;
            repeat (4) @(posedge hclk);
            s_load <= 1'b0;
        end
        repeat (4) @(posedge hclk);
    endtask : ser
endmodule : pllcl_host

`default_nettype wire

// ---- test/pllcl_top_tb.sv ----
`timescale 1ns/1ns
`default_nettype none

module pllcl_top_tb
    import pllcl_pkg::*;
;
    // Small lock limit keeps the run short
    localparam int LOCK_N = 4000;
    localparam logic [31:0] A_CTRL = {24'h0, CTRL_OFFSET};
    localparam logic [31:0] A_ST = {24'h0, STATUS_OFFSET};
    localparam logic [31:0] A_CFG = {24'h0, CONFIG_OFFSET};
    localparam logic [31:0] A_SH = {24'h0, SHIFT_OFFSET};

    typedef struct packed {logic [8:0] fb; logic [1:0] od; logic [31:0] cfg;} pllcl_row_t;
    pllcl_row_t rows [4] = '{'{9'h0a0, 2'h0, 32'h0a0}, '{9'h1ff, 2'h1, 32'h5ff},
        '{9'h106, 2'h2, 32'h906}, '{9'h190, 2'h3, 32'hd90}};

    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic p_load_n, s_clock, s_data, s_load;
    logic [FB_W-1:0] fb_div_in;
    logic [OD_W-1:0] out_div_in;
    logic external_reference_in, synth_output, test_output, tprev, sprev;
    int num_errors, num_checks, trise, t0, srise, s0, shigh, h0;

    assign hready = hreadyout;

    ////////////////////////////////////////////////////////////////////////
    pllcl_top #(.LOCK_CYCLES(LOCK_N)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .p_load_n,
        .fb_div_in, .out_div_in, .s_clock, .s_data, .s_load, .external_reference_in,
        .synth_output, .test_output);

    pllcl_host host (.hclk, .p_load_n, .fb_div_in, .out_div_in, .s_clock, .s_data,
        .s_load);

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // Reference period of ten clocks; a window is then 160 clocks
    initial
    begin
        external_reference_in = 1'b0;
        forever
        begin
            repeat (5) @(posedge hclk);
            external_reference_in <= ~external_reference_in;
        end
    end

    always @(posedge hclk)
    begin
        tprev <= test_output;
        sprev <= synth_output;
        if (test_output === 1'b1 && tprev === 1'b0)
            trise <= trise + 1;
        if (synth_output === 1'b1 && sprev === 1'b0)
            srise <= srise + 1;
        if (synth_output === 1'b1)
            shigh <= shigh + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rdv = hrdata;
    endtask : bus

    task rd(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdv, exp);
    endtask : rd

    task poll(input int b);
        rdv = 32'h0;
        for (int n = 0; n < 10000 && rdv[b] !== 1'b1; n++) bus(1'b0, A_ST, 32'h0);
    endtask : poll

    task print_verdict;
        $display("Checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata, trise, num_errors, num_checks} = '0;
        {srise, shigh} = '0;
        hsize = 3'h2;
        repeat (2) @(posedge hclk);
        chk({31'h0, hreadyout}, 32'h0);
        hresetn <= 1'b1;
        rd(A_CFG, {23'h0, FB_RESET});
        rd(A_CTRL, {30'h0, CTRL_RESET});
        bus(1'b1, A_CTRL, 32'h1);
        rd(A_CTRL, 32'h1);
        bus(1'b1, A_CTRL, {30'h0, CTRL_RESET});
        bus(1'b1, 32'h100, 32'hffff_ffff);
        rd(32'h100, 32'h0);
        foreach (rows[i])
        begin
            host.par(rows[i].fb, rows[i].od, 1'b1);
            rd(A_CFG, rows[i].cfg);
        end
        // Older bits must fall off the far end
        host.ser(14'h3fff, 1'b0);
        host.ser(14'h2ad2, 1'b1);
        rd(A_CFG, 32'ha4d2);
        rd(A_SH, 32'h2ad2);
        host.ser(14'h36c8, 1'b1);
        rd(A_CFG, 32'hccc8);
        t0 = trise;
        host.ser(14'h0, 1'b0);
        chk({31'h0, trise != t0}, 32'h1);
        host.par(9'h0e0, 2'h0, 1'b0);
        t0 = trise;
        host.ser(14'h36c8, 1'b1);
        rd(A_CFG, 32'h0e0);
        chk(trise - t0, 32'h0);
        host.par(9'h0f0, 2'h1, 1'b0);
        rd(A_CFG, 32'h4f0);
        host.par(9'h0c8, 2'h0, 1'b1);
        poll(ST_LOCKED_BIT);
        chk({29'h0, rdv[2:0]}, 32'h5);
        // Test pin shows the oscillator while the output divides by four
        host.ser(14'h0ac8, 1'b1);
        t0 = trise;
        s0 = srise;
        h0 = shigh;
        repeat (2000) @(posedge hclk);
        chk({31'h0, (trise - t0) - 4 * (srise - s0) inside {[-4:4]}}, 32'h1);
        chk({31'h0, 2 * (shigh - h0) - 2000 inside {[-40:40]}}, 32'h1);
        chk({31'h0, srise - s0 > 20}, 32'h1);
        host.par(9'h0a0, 2'h0, 1'b1);
        poll(ST_TIMEOUT_BIT);
        chk({29'h0, rdv[2:0]}, 32'h2);
        print_verdict;
    end

    // Lock waits dominate; this allows several times their sum
    initial
    begin
        #2_000_000;
        num_errors++;
        print_verdict;
    end
endmodule : pllcl_top_tb

bind pllcl_top pllcl_top_asserts chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hrdata, .hreadyout, .hresp, .p_load_n, .fb_div_in, .out_div_in, .test_output);

`default_nettype wire
